/* File: rtl/fspp_pkg.sv */
// Purpose: constants and types for the flash self-program protection block
// Assumes: 32-bit classic Wishbone slave, one clock, synchronous reset
// Notes:   lock bit value 1 is unprogrammed, 0 is programmed
// Function
// - stores from application section never program
// - boot section stores may target any address
// - boot-size fuses split flash into two sections
// - during read-while-write programming only no-read-while-write readable
// - no-read-while-write programming halts the CPU throughout
// - boot section lies inside no-read-while-write section
// - busy flag reads one while section blocked
// - busy flag stays set until software clears
// - lock bits release only by chip erase
// - general write lock never blocks stores
// - general read/write lock never blocks loads/stores
// - application lock pair blocks application writes
// - application lock pair blocks boot reads of application
// - application load locks mask interrupts when vectors boot-side
// - boot lock pair blocks boot section writes
// - boot lock pair blocks application reads of boot
// - boot load locks mask interrupts when vectors application-side
// - reset vector from boot reset fuse
// - busy clears only by re-enable after programming
package fspp_pkg;

    // flash geometry, word addressed
    localparam int FSPP_FLASH_ADDR_W   = 14;
    localparam int FSPP_BOOT_MIN_WORDS = 256;

    // register byte offsets
    localparam logic [7:0] FSPP_OFF_CTRL  = 8'h00;
    localparam logic [7:0] FSPP_OFF_LOCK  = 8'h04;
    localparam logic [7:0] FSPP_OFF_FUSE  = 8'h08;
    localparam logic [7:0] FSPP_OFF_BOUND = 8'h0C;

    // control/status field positions
    localparam int FSPP_CTRL_REENABLE_BIT = 0;
    localparam int FSPP_CTRL_BUSY_BIT     = 1;
    localparam int FSPP_CTRL_HALT_BIT     = 2;
    localparam int FSPP_CTRL_REJECT_BIT   = 3;
    localparam int FSPP_CTRL_IVSEL_BIT    = 4;

    // lock field positions
    localparam int FSPP_LOCK_APP_LOW   = 0;
    localparam int FSPP_LOCK_APP_HIGH  = 1;
    localparam int FSPP_LOCK_BOOT_LOW  = 2;
    localparam int FSPP_LOCK_BOOT_HIGH = 3;

    // reset values
    localparam logic [3:0] FSPP_LOCK_RESET = 4'hF;
    localparam logic       FSPP_IVSEL_RESET = 1'b0;
    localparam int         FSPP_APP_RESET_VECTOR = 0;

    // programming sequencer states
    typedef enum logic [1:0] {
        FSPP_ST_IDLE,
        FSPP_ST_PROG_RWW,
        FSPP_ST_PROG_NO_READ_WHILE_WRITE_SECTION
    } fspp_state_t;

endpackage

/* File: rtl/fspp_section_decode.sv */
// Purpose: map a flash word address onto boot and no-read-while-write areas
// Assumes: boot area sits at the top of flash, sized by two fuses
// Notes:   fuses 11 give the smallest boot area, 00 the largest
module fspp_section_decode #(
    parameter int ADDR_W         = fspp_pkg::FSPP_FLASH_ADDR_W,
    parameter int BOOT_MIN_WORDS = fspp_pkg::FSPP_BOOT_MIN_WORDS
) (
    // address and fuses
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [1:0]        boot_size_fuses,
    // decode results
    output logic                   in_boot,
    output logic                   in_no_read_while_write_section,
    output logic [ADDR_W-1:0]      boot_start
);

    // fixed no-read-while-write area covers the largest boot area
    localparam logic [ADDR_W:0] TOP_WORD = {1'b1, {ADDR_W{1'b0}}};
    localparam logic [ADDR_W:0] NO_READ_WHILE_WRITE_SECTION_WORDS = (ADDR_W+1)'(8 * BOOT_MIN_WORDS);
    localparam logic [ADDR_W:0] NO_READ_WHILE_WRITE_SECTION_FULL = TOP_WORD - NO_READ_WHILE_WRITE_SECTION_WORDS;

    logic [ADDR_W:0] boot_words;
    logic [ADDR_W:0] start_full;

    // boundary from boot-size fuses kept inside no_read_while_write_section area
    assign boot_words = (ADDR_W+1)'(BOOT_MIN_WORDS) << (~boot_size_fuses);
    assign start_full = TOP_WORD - boot_words;
    assign boot_start = start_full[ADDR_W-1:0];
    assign in_boot    = addr >= boot_start;
    assign in_no_read_while_write_section    = addr >= NO_READ_WHILE_WRITE_SECTION_FULL[ADDR_W-1:0];

endmodule // fspp_section_decode

/* File: rtl/fspp_top.sv */
// Purpose: gate store/load program-memory operations and track programming
// Assumes: CPU presents one operation per op_valid cycle; engine pulses done
// Notes:   accept/reject answer one cycle after op_valid
module fspp_top #(
    parameter int ADDR_W         = fspp_pkg::FSPP_FLASH_ADDR_W,
    parameter int BOOT_MIN_WORDS = fspp_pkg::FSPP_BOOT_MIN_WORDS
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              reset,
    // wishbone slave
    input  wire logic              wb_cyc,
    input  wire logic              wb_stb,
    input  wire logic              wb_we,
    input  wire logic [7:0]        wb_adr,
    input  wire logic [3:0]        wb_sel,
    input  wire logic [31:0]       wb_dat_w,
    output logic                   wb_ack,
    output logic [31:0]            wb_dat_r,
    // cpu operations
    input  wire logic              op_valid,
    input  wire logic              op_store,
    input  wire logic              op_lock_set,
    input  wire logic [ADDR_W-1:0] op_addr,
    input  wire logic [3:0]        op_data,
    input  wire logic [ADDR_W-1:0] exec_pc,
    output logic                   op_accept,
    output logic                   op_reject,
    // programming engine
    input  wire logic              prog_done,
    output logic                   prog_start,
    output logic [ADDR_W-1:0]      prog_addr,
    output logic                   prog_no_read_while_write_section,
    // cpu control
    output logic                   cpu_halt,
    output logic                   rww_read_block,
    output logic                   irq_disable,
    output logic [ADDR_W-1:0]      reset_vector,
    // fuses and lock storage
    input  wire logic [1:0]        boot_size_fuses,
    input  wire logic              boot_reset_vector_fuse,
    input  wire logic [3:0]        lock_init,
    input  wire logic              ext_lock_write,
    input  wire logic [3:0]        ext_lock_data,
    input  wire logic              chip_erase,
    output logic [3:0]             lock_bits
);

    typedef struct packed {
        fspp_pkg::fspp_state_t state;
        logic                  wb_ack;
        logic [31:0]           wb_dat;
        logic                  busy;
        logic [3:0]            locks;
        logic                  locks_loaded;
        logic                  ivsel;
        logic                  reject_sticky;
        logic                  op_accept;
        logic                  op_reject;
        logic                  prog_start;
        logic [ADDR_W-1:0]     prog_addr;
        logic                  prog_no_read_while_write_section;
        logic                  cpu_halt;
        logic                  irq_disable;
        logic [ADDR_W-1:0]     reset_vector;
    } fspp_regs_t;

    fspp_regs_t s;
    fspp_regs_t next_s;

    logic              pc_in_boot;
    logic              tgt_in_boot;
    logic              tgt_no_read_while_write_section;
    logic [ADDR_W-1:0] boot_start;
    logic              wb_req;
    logic              store_blocked;
    logic              load_blocked;
    logic              ctrl_write;

    // where the code runs and where the operation points
    fspp_section_decode #(
        .ADDR_W         (ADDR_W),
        .BOOT_MIN_WORDS (BOOT_MIN_WORDS)
    ) u_pc_decode (
        .addr            (exec_pc),
        .boot_size_fuses (boot_size_fuses),
        .in_boot         (pc_in_boot),
        .in_no_read_while_write_section         (),
        .boot_start      (boot_start)
    );

    fspp_section_decode #(
        .ADDR_W         (ADDR_W),
        .BOOT_MIN_WORDS (BOOT_MIN_WORDS)
    ) u_tgt_decode (
        .addr            (op_addr),
        .boot_size_fuses (boot_size_fuses),
        .in_boot         (tgt_in_boot),
        .in_no_read_while_write_section         (tgt_no_read_while_write_section),
        .boot_start      ()
    );

    // bus request and control register write strobe
    assign wb_req     = wb_cyc & wb_stb & ~s.wb_ack;
    assign ctrl_write = wb_req & wb_we & wb_sel[0] & (wb_adr == fspp_pkg::FSPP_OFF_CTRL);

    // store gating: pc in boot, idle sequencer and the target's boot or application lock pair decide, general lock has no say
    always_comb begin
        store_blocked = ~pc_in_boot
            | (tgt_in_boot ? ~s.locks[fspp_pkg::FSPP_LOCK_BOOT_LOW]
                           : ~s.locks[fspp_pkg::FSPP_LOCK_APP_LOW])
            | (s.state != fspp_pkg::FSPP_ST_IDLE);
        load_blocked = (pc_in_boot & ~tgt_in_boot
                        & ~s.locks[fspp_pkg::FSPP_LOCK_APP_HIGH])
            | (~pc_in_boot & tgt_in_boot
               & ~s.locks[fspp_pkg::FSPP_LOCK_BOOT_HIGH])
            | (s.busy & ~tgt_no_read_while_write_section)
            | (s.state == fspp_pkg::FSPP_ST_PROG_NO_READ_WHILE_WRITE_SECTION);
    end

    // next-state logic
    always_comb begin
        next_s            = s;
        next_s.op_accept  = 1'b0;
        next_s.op_reject  = 1'b0;
        next_s.prog_start = 1'b0;
        next_s.wb_ack     = wb_req;

        // lock image taken once after reset release
        if (!s.locks_loaded) begin
            next_s.locks        = lock_init;
            next_s.locks_loaded = 1'b1;
        end

        // programming finished
        if (prog_done && s.state != fspp_pkg::FSPP_ST_IDLE) begin
            next_s.state    = fspp_pkg::FSPP_ST_IDLE;
            next_s.cpu_halt = 1'b0;
        end

        // busy clears only by re-enable once idle
        if (ctrl_write && wb_dat_w[fspp_pkg::FSPP_CTRL_REENABLE_BIT]
            && s.state == fspp_pkg::FSPP_ST_IDLE) begin
            next_s.busy = 1'b0;
        end
        if (ctrl_write) begin
            next_s.ivsel = wb_dat_w[fspp_pkg::FSPP_CTRL_IVSEL_BIT];
            if (wb_dat_w[fspp_pkg::FSPP_CTRL_REJECT_BIT]) begin
                next_s.reject_sticky = 1'b0;
            end
        end

        // cpu operations
        if (op_valid && s.locks_loaded) begin
            if (op_store && op_lock_set) begin
                // lock bits only move toward programmed
                if (pc_in_boot) begin
                    next_s.locks     = next_s.locks & op_data;
                    next_s.op_accept = 1'b1;
                end else begin
                    next_s.op_reject = 1'b1;
                end
            end else if (op_store) begin
                if (store_blocked) begin
                    next_s.op_reject = 1'b1;
                end else begin
                    // any target, boot area included
                    next_s.op_accept  = 1'b1;
                    next_s.prog_start = 1'b1;
                    next_s.prog_addr  = op_addr;
                    next_s.prog_no_read_while_write_section  = tgt_no_read_while_write_section;
                    if (tgt_no_read_while_write_section) begin
                        next_s.state    = fspp_pkg::FSPP_ST_PROG_NO_READ_WHILE_WRITE_SECTION;
                        next_s.cpu_halt = 1'b1;
                    end else begin
                        next_s.state = fspp_pkg::FSPP_ST_PROG_RWW;
                        next_s.busy  = 1'b1;
                    end
                end
            end else if (load_blocked) begin
                next_s.op_reject = 1'b1;
            end else begin
                next_s.op_accept = 1'b1;
            end
        end else if (op_valid) begin
            next_s.op_reject = 1'b1;
        end

        // serial/parallel programming then chip erase
        if (ext_lock_write) begin
            next_s.locks = next_s.locks & ext_lock_data;
        end
        if (chip_erase) begin
            next_s.locks = fspp_pkg::FSPP_LOCK_RESET;
        end

        // sticky reject: set wins over clear
        if (next_s.op_reject) begin
            next_s.reject_sticky = 1'b1;
        end

        // interrupt masking by load-restricting lock modes
        next_s.irq_disable =
            (s.ivsel & ~pc_in_boot & ~s.locks[fspp_pkg::FSPP_LOCK_APP_HIGH])
            | (~s.ivsel & pc_in_boot & ~s.locks[fspp_pkg::FSPP_LOCK_BOOT_HIGH]);

        // reset vector from fuse
        next_s.reset_vector = boot_reset_vector_fuse
            ? ADDR_W'(fspp_pkg::FSPP_APP_RESET_VECTOR) : boot_start;

        // register read mux
        next_s.wb_dat = 32'h0000_0000;
        if (wb_req && !wb_we) begin
            unique case (wb_adr)
                fspp_pkg::FSPP_OFF_CTRL: begin
                    next_s.wb_dat[fspp_pkg::FSPP_CTRL_BUSY_BIT]   = s.busy;
                    next_s.wb_dat[fspp_pkg::FSPP_CTRL_HALT_BIT]   = s.cpu_halt;
                    next_s.wb_dat[fspp_pkg::FSPP_CTRL_REJECT_BIT] = s.reject_sticky;
                    next_s.wb_dat[fspp_pkg::FSPP_CTRL_IVSEL_BIT]  = s.ivsel;
                end
                fspp_pkg::FSPP_OFF_LOCK:  next_s.wb_dat[3:0] = s.locks;
                fspp_pkg::FSPP_OFF_FUSE:  next_s.wb_dat[2:0] =
                    {boot_reset_vector_fuse, boot_size_fuses};
                fspp_pkg::FSPP_OFF_BOUND: next_s.wb_dat[ADDR_W-1:0] = boot_start;
                default:                  next_s.wb_dat = 32'h0000_0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s              <= '0;
            s.state        <= fspp_pkg::FSPP_ST_IDLE;
            s.locks        <= fspp_pkg::FSPP_LOCK_RESET;
            s.ivsel        <= fspp_pkg::FSPP_IVSEL_RESET;
            s.reset_vector <= ADDR_W'(fspp_pkg::FSPP_APP_RESET_VECTOR);
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign wb_ack         = s.wb_ack;
    assign wb_dat_r       = s.wb_dat;
    assign op_accept      = s.op_accept;
    assign op_reject      = s.op_reject;
    assign prog_start     = s.prog_start;
    assign prog_addr      = s.prog_addr;
    assign prog_no_read_while_write_section      = s.prog_no_read_while_write_section;
    assign cpu_halt       = s.cpu_halt;
    assign rww_read_block = s.busy;
    assign irq_disable    = s.irq_disable;
    assign reset_vector   = s.reset_vector;
    assign lock_bits      = s.locks;

    // checks on the operation gating
    AST_STORE_FROM_APP: assert property (@(posedge clk_sys) disable iff (reset)
        op_valid && op_store && !pc_in_boot && s.locks_loaded |=> op_reject && !prog_start)
        else $error("store from application section was not refused");

    AST_HALT_NO_READ_WHILE_WRITE_SECTION: assert property (@(posedge clk_sys) disable iff (reset)
        prog_start && prog_no_read_while_write_section |-> cpu_halt until prog_done)
        else $error("cpu not halted during no_read_while_write_section programming");

    AST_BUSY_RWW: assert property (@(posedge clk_sys) disable iff (reset)
        prog_start && !prog_no_read_while_write_section |-> rww_read_block)
        else $error("busy flag not set for rww programming");

    AST_BUSY_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
        rww_read_block && !ctrl_write |=> rww_read_block)
        else $error("busy flag dropped without re-enable write");

    AST_APP_WRITE_LOCK: assert property (@(posedge clk_sys) disable iff (reset)
        op_valid && op_store && !op_lock_set && !tgt_in_boot
        && !s.locks[fspp_pkg::FSPP_LOCK_APP_LOW] |=> !prog_start && op_reject)
        else $error("locked application write started programming");

    AST_BOOT_READ_LOCK: assert property (@(posedge clk_sys) disable iff (reset)
        op_valid && !op_store && s.locks_loaded && !pc_in_boot && tgt_in_boot
        && !s.locks[fspp_pkg::FSPP_LOCK_BOOT_HIGH] |=> op_reject)
        else $error("locked boot read was allowed");

    AST_LOCK_NO_RELEASE: assert property (@(posedge clk_sys) disable iff (reset)
        s.locks_loaded && !chip_erase |=> (lock_bits & ~$past(lock_bits)) == 4'h0)
        else $error("lock bit returned to unprogrammed without chip erase");

    AST_RESET_VECTOR: assert property (@(posedge clk_sys) disable iff (reset)
        boot_reset_vector_fuse ##1 boot_reset_vector_fuse |-> reset_vector == '0)
        else $error("reset vector not zero with fuse unprogrammed");

    AST_REENABLE: assert property (@(posedge clk_sys) disable iff (reset)
        ctrl_write && wb_dat_w[0] && s.state == fspp_pkg::FSPP_ST_IDLE
        && !(op_valid && op_store) |=> !rww_read_block ##1 !wb_ack)
        else $error("re-enable did not clear busy flag");

endmodule // fspp_top

/* File: bench/fspp_engine_model.sv */
// Purpose: programming engine model answering each start with one done pulse
// Assumes: one erase/write at a time, started by a one-cycle start pulse
// Notes:   slow selects a long erase/write time so mid-operation checks fit
module fspp_engine_model (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // engine control
    input  wire logic slow,
    input  wire logic prog_start,
    output logic      prog_done
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned left;

    // count down the erase/write time, then pulse done once
    always @(posedge clk_sys) begin
        prog_done <= 1'b0;
        if (reset) begin
            left <= 0;
        end else if (prog_start) begin
            left <= slow ? 40 : 3;
        end else if (left == 1) begin
            left      <= 0;
            prog_done <= 1'b1;
        end else if (left != 0) begin
            left <= left - 1;
        end
    end
endmodule // fspp_engine_model

/* File: bench/flash_self_program_protect_test.sv */
// Purpose: self-checking bench for the flash self-program protection block
// Assumes: fuses 11 put the boot area at 0x3F00, engine model answers starts
// Notes:   each scenario is one task that drives and judges
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("Error t=%0t got %0h exp %0h", $time, (got), (exp)); \
    end \
end
module flash_self_program_protect_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [13:0] A_RWW  = 14'h0040;
    localparam logic [13:0] A_NO_READ_WHILE_WRITE_SECTION = 14'h3A00;
    localparam logic [13:0] A_BOOT = 14'h3F80;
    localparam logic [13:0] PC_BT  = 14'h3F10;
    localparam logic [13:0] PC_AP  = 14'h0100;
    localparam logic [7:0]  CTRL   = fspp_pkg::FSPP_OFF_CTRL;
    // driven inputs
    logic        clk_sys = 1'b0, reset = 1'b1, slow = 1'b0;
    logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic        op_valid = 1'b0, op_store = 1'b0, op_lock_set = 1'b0;
    logic [13:0] op_addr = 14'h0, exec_pc = 14'h0;
    logic [3:0]  op_data = 4'h0, lock_init = 4'hF, ext_lock_data = 4'hF;
    logic [1:0]  boot_size_fuses = 2'b11;
    logic        boot_reset_vector_fuse = 1'b1, ext_lock_write = 1'b0, chip_erase = 1'b0;
    // observed outputs
    logic        wb_ack, op_accept, op_reject, prog_done, prog_start, prog_no_read_while_write_section;
    logic        cpu_halt, rww_read_block, irq_disable;
    logic [31:0] wb_dat_r, q;
    logic [13:0] prog_addr, reset_vector;
    logic [3:0]  lock_bits;
    logic        acc, rej, pst, pnrww;
    int          err_total = 0, samples_checked = 0;

    fspp_top u_fspp_top (.clk_sys(clk_sys), .reset(reset), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r), .op_valid(op_valid),
        .op_store(op_store), .op_lock_set(op_lock_set), .op_addr(op_addr),
        .op_data(op_data), .exec_pc(exec_pc), .op_accept(op_accept),
        .op_reject(op_reject), .prog_done(prog_done), .prog_start(prog_start),
        .prog_addr(prog_addr), .prog_no_read_while_write_section(prog_no_read_while_write_section), .cpu_halt(cpu_halt),
        .rww_read_block(rww_read_block), .irq_disable(irq_disable),
        .reset_vector(reset_vector), .boot_size_fuses(boot_size_fuses),
        .boot_reset_vector_fuse(boot_reset_vector_fuse), .lock_init(lock_init),
        .ext_lock_write(ext_lock_write), .ext_lock_data(ext_lock_data),
        .chip_erase(chip_erase), .lock_bits(lock_bits));

    fspp_engine_model u_fspp_engine_model (.clk_sys(clk_sys), .reset(reset),
        .slow(slow), .prog_start(prog_start), .prog_done(prog_done));

    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;

    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= adr;
        wb_sel   <= 4'hF;
        wb_dat_w <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1);
        `CHK(n, 2) // ack stands one cycle after the request edge
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    // one cpu operation, answer sampled one cycle after it is taken
    task automatic op(input logic st, input logic ls, input logic [13:0] pc,
                      input logic [13:0] a, input logic [3:0] d);
        @(posedge clk_sys);
        exec_pc     <= pc;
        op_valid    <= 1'b1;
        op_store    <= st;
        op_lock_set <= ls;
        op_addr     <= a;
        op_data     <= d;
        @(posedge clk_sys);
        op_valid <= 1'b0;
        @(posedge clk_sys);
        acc   = op_accept;
        rej   = op_reject;
        pst   = prog_start;
        pnrww = prog_no_read_while_write_section;
    endtask

    // wait for the engine, then the halt must be gone
    task automatic finish_prog();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (prog_done !== 1'b1 && n < 100);
        `CHK(n < 100, 1'b1)
        repeat (2) @(posedge clk_sys);
        `CHK(cpu_halt, 1'b0)
    endtask

    // re-enable reads of the busy section
    task automatic clr();
        wb(1'b1, CTRL, 32'h0000_0001);
    endtask

    // erase locks back to all ones
    task automatic erase();
        @(posedge clk_sys);
        chip_erase <= 1'b1;
        @(posedge clk_sys);
        chip_erase <= 1'b0;
        @(posedge clk_sys);
        `CHK(lock_bits, 4'hF)
    endtask

    // reset values and fuse-derived map
    task automatic t_reset();
        `CHK(lock_bits, 4'hF)
        `CHK(reset_vector, 14'h0000)
        wb(1'b0, fspp_pkg::FSPP_OFF_FUSE, 32'h0);
        `CHK(q, 32'h0000_0007)
        wb(1'b0, fspp_pkg::FSPP_OFF_BOUND, 32'h0);
        `CHK(q, 32'h0000_3F00)
        wb(1'b0, 8'h40, 32'h0);
        `CHK(q, 32'h0000_0000)
        $display("test reset done");
    endtask

    // stores and lock sets from the application area do nothing
    task automatic t_app();
        op(1'b1, 1'b0, PC_AP, A_RWW, 4'h0);
        `CHK({acc, rej, pst}, 3'b010)
        op(1'b1, 1'b1, PC_AP, 14'h0000, 4'h0);
        @(posedge clk_sys);
        `CHK({rej, lock_bits}, 5'h1F)
        $display("test app store done");
    endtask

    // programming the read-while-write area, busy flag life cycle
    task automatic t_rww();
        slow <= 1'b1;
        op(1'b1, 1'b0, PC_BT, A_RWW, 4'h0);
        `CHK({acc, pst, pnrww, prog_addr}, {3'b110, A_RWW})
        `CHK({rww_read_block, cpu_halt}, 2'b10)
        op(1'b0, 1'b0, PC_BT, A_RWW, 4'h0);
        `CHK({acc, rej}, 2'b01)
        op(1'b0, 1'b0, PC_BT, A_NO_READ_WHILE_WRITE_SECTION, 4'h0);
        `CHK({acc, rej}, 2'b10)
        clr();
        `CHK(rww_read_block, 1'b1)
        finish_prog();
        `CHK(rww_read_block, 1'b1)
        wb(1'b0, CTRL, 32'h0);
        `CHK(q[fspp_pkg::FSPP_CTRL_BUSY_BIT], 1'b1)
        clr();
        @(posedge clk_sys);
        `CHK(rww_read_block, 1'b0)
        op(1'b0, 1'b0, PC_BT, A_RWW, 4'h0); // read only after re-enable
        `CHK(acc, 1'b1)
        $display("test rww done");
    endtask

    // programming the boot area halts the cpu and blocks all loads
    task automatic t_no_read_while_write_section();
        op(1'b1, 1'b0, PC_BT, A_BOOT, 4'h0);
        `CHK({acc, pst, pnrww}, 3'b111)
        `CHK(cpu_halt, 1'b1)
        op(1'b0, 1'b0, PC_BT, A_NO_READ_WHILE_WRITE_SECTION, 4'h0);
        `CHK(rej, 1'b1)
        wb(1'b0, CTRL, 32'h0);
        `CHK(q, 32'h0000_000C)
        finish_prog();
        clr();
        wb(1'b1, CTRL, 32'h0000_0008);
        wb(1'b0, CTRL, 32'h0);
        `CHK(q, 32'h0000_0000)
        slow <= 1'b0;
        $display("test no_read_while_write_section done");
    endtask

    // every lock pair setting, same value on both pairs
    task automatic t_locks();
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = i[1:0];
            erase();
            ext_lock_write <= 1'b1;
            ext_lock_data  <= {m, m};
            @(posedge clk_sys);
            ext_lock_write <= 1'b0;
            @(posedge clk_sys);
            `CHK(lock_bits, {m, m})
            wb(1'b1, CTRL, 32'h0000_0010);
            exec_pc <= PC_AP;
            repeat (3) @(posedge clk_sys);
            `CHK(irq_disable, ~m[1])
            wb(1'b1, CTRL, 32'h0000_0000);
            exec_pc <= PC_BT;
            repeat (3) @(posedge clk_sys);
            `CHK(irq_disable, ~m[1])
            op(1'b1, 1'b0, PC_BT, A_RWW, 4'h0);
            `CHK({acc, pst}, {m[0], m[0]})
            if (acc === 1'b1) finish_prog();
            clr();
            op(1'b0, 1'b0, PC_BT, A_RWW, 4'h0);
            `CHK(acc, m[1])
            op(1'b1, 1'b0, PC_BT, A_BOOT, 4'h0);
            `CHK({acc, pst}, {m[0], m[0]})
            if (acc === 1'b1) finish_prog();
            clr();
            op(1'b0, 1'b0, PC_AP, A_BOOT, 4'h0);
            `CHK(acc, m[1])
        end
        erase();
        op(1'b1, 1'b1, PC_BT, 14'h0000, 4'h0);
        @(posedge clk_sys);
        `CHK({acc, lock_bits}, 5'h10)
        erase();
        $display("test locks done");
    endtask

    // largest boot area and boot reset vector
    task automatic t_fuse();
        @(posedge clk_sys);
        boot_reset_vector_fuse <= 1'b0;
        boot_size_fuses        <= 2'b00;
        repeat (3) @(posedge clk_sys);
        `CHK(reset_vector, 14'h3800)
        wb(1'b0, fspp_pkg::FSPP_OFF_BOUND, 32'h0);
        `CHK(q, 32'h0000_3800)
        op(1'b1, 1'b0, 14'h3800, 14'h3800, 4'h0);
        `CHK({acc, pnrww}, 2'b11)
        finish_prog();
        clr();
        $display("test fuse done");
    endtask

    // mid-run reset picks up a new lock image
    task automatic t_reset_again();
        @(posedge clk_sys);
        reset     <= 1'b1;
        lock_init <= 4'hA;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK({lock_bits, reset_vector}, {4'hA, 14'h3800})
        op(1'b1, 1'b0, PC_BT, A_RWW, 4'h0);
        `CHK({acc, rej, pst}, 3'b010)
        $display("test reset again done");
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (2) @(posedge clk_sys);
        t_reset();
        t_app();
        t_rww();
        t_no_read_while_write_section();
        t_locks();
        t_fuse();
        t_reset_again();
        conclude();
    end

    // watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        conclude();
    end
endmodule // flash_self_program_protect_test
